// >>> design/sffo_pkg.sv
// Purpose: Shared constants and helpers for the feed-forward and speed observer stage
// Assumes: core_clk at 25 MHz; all setting ports are static or change on core_clk
// Notes:   Torque is signed 0.1 % units, positive = counter_clockwise

package sffo_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int CTRL_PERIOD_NS = 50000;
   localparam int CTRL_PERIOD_CYCLES = CTRL_PERIOD_NS / CLK_PERIOD_NS;
   localparam int CYC_W = 11;
   localparam logic [CYC_W-1:0] CYC_LAST = CYC_W'(CTRL_PERIOD_CYCLES - 1);
   localparam logic [CYC_W-1:0] CYC_RESET = 11'h000;
   // One filter setting count is 0.01 ms
   localparam int FF_FILTER_LSB_NS = 10000;

   // ------------------------------------------------------------
   // Gains and scaling
   // ------------------------------------------------------------
   // Feed-forward gains are in 0.1 % steps, 1000 = 100 %
   localparam longint FF_GAIN_FULL = 1000;
   localparam longint INERTIA_BASE = 100;
   localparam longint ACCEL_TO_TORQUE_NUM = 1;
   localparam longint ACCEL_TO_TORQUE_DEN = 1;
   localparam longint TORQUE_TO_ACCEL_NUM = 1;
   localparam longint TORQUE_TO_ACCEL_DEN = 16;
   localparam int OBS_CORR_SHIFT = 3;
   // Analog voltage in mV; torque in 0.1 % gives 10 * mV / gain
   localparam longint ATFF_MV_SCALE = 10;
   localparam logic [15:0] ATFF_GAIN_MIN = 16'h000A;

   // ------------------------------------------------------------
   // Setting fields
   // ------------------------------------------------------------
   localparam int FES_OBS_EN_BIT = 0;
   localparam int FES_ATFF_EN_BIT = 5;
   localparam logic [3:0] MODE_POSITION = 4'h0;
   localparam logic [3:0] MODE_VELOCITY = 4'h1;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic signed [31:0] SPEED_RESET = 32'sh0000_0000;
   localparam logic signed [15:0] TORQUE_RESET = 16'sh0000;

   // ------------------------------------------------------------
   // Saturating narrowers
   // ------------------------------------------------------------
   function automatic logic signed [31:0] sffo_sat32(input logic signed [63:0] v);
      if (v > 64'sh0000_0000_7FFF_FFFF) begin
         return 32'sh7FFF_FFFF;
      end else if (v < -64'sh0000_0000_8000_0000) begin
         return -32'sh8000_0000;
      end
      return v[31:0];
   endfunction : sffo_sat32

   function automatic logic signed [15:0] sffo_sat16(input logic signed [63:0] v);
      if (v > 64'sh0000_0000_0000_7FFF) begin
         return 16'sh7FFF;
      end else if (v < -64'sh0000_0000_0000_8000) begin
         return -16'sh8000;
      end
      return v[15:0];
   endfunction : sffo_sat16

endpackage : sffo_pkg

// >>> design/sffo_lag_filter.sv
// Purpose: First-order delay filter stepped once per control cycle
// Assumes: step is a one-cycle pulse on core_clk
// Notes:   Setting 0 passes the input straight through

`timescale 1ns/1ns
`default_nettype none

module sffo_lag_filter
   import sffo_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Control
   input wire logic step,
   input wire logic [15:0] tau_setting,
   // Data
   input wire logic signed [31:0] x_in,
   output logic signed [31:0] y_out
);

   logic signed [31:0] y_reg;
   logic signed [31:0] y_next;
   logic signed [63:0] diff;
   logic signed [63:0] tau_ns;
   logic signed [63:0] denom;
   logic signed [63:0] delta;

   // ------------------------------------------------------------
   // Update y += (x - y) * T / (T + tau)
   // ------------------------------------------------------------
   assign diff = 64'(x_in) - 64'(y_reg);
   assign tau_ns = $signed({48'h0000_0000_0000, tau_setting}) * 64'(FF_FILTER_LSB_NS);
   assign denom = 64'(CTRL_PERIOD_NS) + tau_ns;
   assign delta = (diff * 64'(CTRL_PERIOD_NS)) / denom;
   assign y_next = (tau_setting == 16'h0000) ? x_in : sffo_sat32(64'(y_reg) + delta);

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         y_reg <= SPEED_RESET;
      end else if (step) begin
         y_reg <= y_next;
      end
   end

   assign y_out = y_reg;

endmodule : sffo_lag_filter

`default_nettype wire

// >>> design/sffo_speed_observer.sv
// Purpose: Load-model speed estimate with correction toward detected speed
// Assumes: step is a one-cycle pulse on core_clk
// Notes:   Estimate tracks detected speed while disabled, so enabling is bumpless

`timescale 1ns/1ns
`default_nettype none

module sffo_speed_observer
   import sffo_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Control
   input wire logic step,
   input wire logic enable,
   input wire logic [15:0] inertia_ratio,
   // Model inputs
   input wire logic signed [15:0] torque_cmd,
   input wire logic signed [31:0] speed_detect,
   // Estimate
   output logic signed [31:0] speed_est
);

   logic signed [31:0] est_reg;
   logic signed [31:0] est_next;
   logic signed [63:0] inertia_tot;
   logic signed [63:0] accel_model;
   logic signed [63:0] corr;

   // ------------------------------------------------------------
   // Model acceleration scaled by total inertia, plus correction
   // ------------------------------------------------------------
   assign inertia_tot = INERTIA_BASE + $signed({48'h0000_0000_0000, inertia_ratio});
   assign accel_model = (64'(torque_cmd) * TORQUE_TO_ACCEL_NUM * INERTIA_BASE)
                        / (inertia_tot * TORQUE_TO_ACCEL_DEN);
   assign corr = (64'(speed_detect) - 64'(est_reg)) >>> OBS_CORR_SHIFT;
   assign est_next = enable ? sffo_sat32(64'(est_reg) + accel_model + corr) : speed_detect;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         est_reg <= SPEED_RESET;
      end else if (step) begin
         est_reg <= est_next;
      end
   end

   assign speed_est = est_reg;

endmodule : sffo_speed_observer

`default_nettype wire

// >>> design/sffo_core.sv
// Purpose: Feed-forward and speed observer stage of the servo control datapath
// Assumes: All inputs come from logic on core_clk; settings change rarely
// Notes:   Outputs update once per control cycle, on the ctrl_cycle pulse
//
// Overview of operation
// - Velocity demand times velocity gain is added to the speed command.
// - Steady deviation shrinks with (100 - gain percent)/100, zero at full gain.
// - Velocity feed-forward passes a first-order lag set by its filter setting.
// - One filter count is 0.01 ms; 50 gives 0.5 ms.
// - Torque demand times torque gain is added to the torque command.
// - Torque feed-forward passes a first-order lag set by its filter setting.
// - Inertia ratio converts acceleration demand into torque demand.
// - Analog feed-forward scaled by conversion gain; settings 0 to 9 invalid.
// - Function expansion bit 5 enables analog torque feed-forward.
// - Analog feed-forward off while analog input 3 serves another function.
// - Analog torque percent is 100 times volts over gain times 0.1.
// - Positive voltage gives counter_clockwise torque, negative gives clockwise.
// - Function expansion bit 0 swaps detected speed for the observer estimate.
// - Observer works only in position or velocity control mode.

`timescale 1ns/1ns
`default_nettype none

module sffo_core
   import sffo_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Position command and loop outputs
   input wire logic signed [31:0] pos_cmd,
   input wire logic signed [31:0] pos_loop_speed_cmd,
   input wire logic signed [15:0] vel_loop_torque_cmd,
   // Feedback and analog input
   input wire logic signed [31:0] speed_detect,
   input wire logic signed [15:0] analog_in3_mv,
   input wire logic ain3_other_function,
   input wire logic servo_on,
   // Settings
   input wire logic [15:0] velocity_ff_gain,
   input wire logic [15:0] velocity_ff_filter,
   input wire logic [15:0] torque_ff_gain,
   input wire logic [15:0] torque_ff_filter,
   input wire logic [15:0] analog_torque_ff_conversion_gain,
   input wire logic [15:0] function_expansion_setting,
   input wire logic [3:0] control_mode_select,
   input wire logic [15:0] inertia_ratio,
   // Commands out
   output logic signed [31:0] speed_cmd_out,
   output logic signed [15:0] torque_cmd_out,
   output logic signed [31:0] speed_fb_out,
   // Status
   output logic ctrl_cycle,
   output logic observer_active,
   output logic analog_ff_active
);

   // ------------------------------------------------------------
   // Control cycle timer
   // ------------------------------------------------------------
   logic [CYC_W-1:0] cyc_cnt_reg;
   logic [CYC_W-1:0] cyc_cnt_next;
   logic step_reg;
   wire cyc_wrap;

   assign cyc_wrap = (cyc_cnt_reg == CYC_LAST);
   assign cyc_cnt_next = cyc_wrap ? CYC_RESET : cyc_cnt_reg + 11'h001;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cyc_cnt_reg <= CYC_RESET;
         step_reg <= 1'b0;
      end else begin
         cyc_cnt_reg <= cyc_cnt_next;
         step_reg <= cyc_wrap;
      end
   end

   assign ctrl_cycle = step_reg;

   // ------------------------------------------------------------
   // Velocity feed-forward
   // ------------------------------------------------------------
   logic signed [31:0] pos_cmd_prev_reg;
   logic signed [31:0] vel_demand;
   logic signed [63:0] vff_raw;
   logic signed [31:0] vff_in;
   logic signed [31:0] vff_filt;

   // Wrapping difference is the per-cycle command velocity
   assign vel_demand = pos_cmd - pos_cmd_prev_reg;
   // Gain 1000 cancels the steady lag term entirely
   assign vff_raw = (64'(vel_demand) * $signed({48'h0000_0000_0000, velocity_ff_gain}))
                    / FF_GAIN_FULL;
   assign vff_in = sffo_sat32(vff_raw);

   sffo_lag_filter u_vff_filter (
      .core_clk(core_clk),
      .rstn(rstn),
      .step(step_reg),
      .tau_setting(velocity_ff_filter),
      .x_in(vff_in),
      .y_out(vff_filt)
   );

   // ------------------------------------------------------------
   // Speed command
   // ------------------------------------------------------------
   logic signed [31:0] speed_cmd_reg;
   logic signed [31:0] speed_cmd_prev_reg;
   logic signed [31:0] speed_cmd_next;

   assign speed_cmd_next = sffo_sat32(64'(pos_loop_speed_cmd) + 64'(vff_filt));

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pos_cmd_prev_reg <= SPEED_RESET;
         speed_cmd_reg <= SPEED_RESET;
         speed_cmd_prev_reg <= SPEED_RESET;
      end else if (step_reg) begin
         pos_cmd_prev_reg <= pos_cmd;
         speed_cmd_reg <= speed_cmd_next;
         speed_cmd_prev_reg <= speed_cmd_reg;
      end
   end

   assign speed_cmd_out = speed_cmd_reg;

   // ------------------------------------------------------------
   // Torque feed-forward
   // ------------------------------------------------------------
   logic signed [31:0] accel_demand;
   logic signed [63:0] inertia_tot;
   logic signed [63:0] torque_demand;
   logic signed [63:0] tff_raw;
   logic signed [31:0] tff_in;
   logic signed [31:0] tff_filt;

   // Acceleration from the speed command step of the last cycle
   assign accel_demand = sffo_sat32(64'(speed_cmd_reg) - 64'(speed_cmd_prev_reg));
   assign inertia_tot = INERTIA_BASE + $signed({48'h0000_0000_0000, inertia_ratio});
   assign torque_demand = (64'(accel_demand) * ACCEL_TO_TORQUE_NUM * inertia_tot)
                          / (INERTIA_BASE * ACCEL_TO_TORQUE_DEN);
   assign tff_raw = (torque_demand * $signed({48'h0000_0000_0000, torque_ff_gain}))
                    / FF_GAIN_FULL;
   assign tff_in = sffo_sat32(tff_raw);

   sffo_lag_filter u_tff_filter (
      .core_clk(core_clk),
      .rstn(rstn),
      .step(step_reg),
      .tau_setting(torque_ff_filter),
      .x_in(tff_in),
      .y_out(tff_filt)
   );

   // ------------------------------------------------------------
   // Analog torque feed-forward
   // ------------------------------------------------------------
   wire atff_gain_ok;
   wire atff_enable;
   logic signed [63:0] atff_raw;
   logic signed [63:0] atff_term;

   assign atff_gain_ok = (analog_torque_ff_conversion_gain >= ATFF_GAIN_MIN);
   assign atff_enable = function_expansion_setting[FES_ATFF_EN_BIT]
                        && !ain3_other_function
                        && atff_gain_ok;
   // 100 * V / (gain * 0.1) percent, here in 0.1 % from mV
   assign atff_raw = atff_gain_ok
                     ? (64'(analog_in3_mv) * ATFF_MV_SCALE)
                       / $signed({48'h0000_0000_0000, analog_torque_ff_conversion_gain})
                     : 64'sh0;
   // Sign kept: positive is counter_clockwise, negative clockwise
   assign atff_term = atff_enable ? atff_raw : 64'sh0;

   // ------------------------------------------------------------
   // Torque command
   // ------------------------------------------------------------
   logic signed [15:0] torque_cmd_reg;
   logic signed [15:0] torque_cmd_next;
   logic analog_ff_active_reg;

   assign torque_cmd_next = sffo_sat16(64'(vel_loop_torque_cmd) + 64'(tff_filt)
                                       + atff_term);

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         torque_cmd_reg <= TORQUE_RESET;
         analog_ff_active_reg <= 1'b0;
      end else if (step_reg) begin
         torque_cmd_reg <= torque_cmd_next;
         analog_ff_active_reg <= atff_enable;
      end
   end

   assign torque_cmd_out = torque_cmd_reg;
   assign analog_ff_active = analog_ff_active_reg;

   // ------------------------------------------------------------
   // Instantaneous speed observer
   // ------------------------------------------------------------
   wire mode_obs_ok;
   wire obs_enable;
   logic signed [31:0] speed_est;
   logic signed [31:0] speed_fb_reg;
   logic observer_active_reg;

   assign mode_obs_ok = (control_mode_select == MODE_POSITION)
                        || (control_mode_select == MODE_VELOCITY);
   // Auto-tune setting is the operator's concern; servo_on only gates
   assign obs_enable = function_expansion_setting[FES_OBS_EN_BIT]
                       && mode_obs_ok && servo_on;

   sffo_speed_observer u_observer (
      .core_clk(core_clk),
      .rstn(rstn),
      .step(step_reg),
      .enable(obs_enable),
      .inertia_ratio(inertia_ratio),
      .torque_cmd(torque_cmd_reg),
      .speed_detect(speed_detect),
      .speed_est(speed_est)
   );

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         speed_fb_reg <= SPEED_RESET;
         observer_active_reg <= 1'b0;
      end else if (step_reg) begin
         speed_fb_reg <= obs_enable ? speed_est : speed_detect;
         observer_active_reg <= obs_enable;
      end
   end

   assign speed_fb_out = speed_fb_reg;
   assign observer_active = observer_active_reg;

endmodule : sffo_core

`default_nettype wire

// >>> dv/sffo_core_monitor.sv
// Purpose: Port-level checks for the feed-forward and observer stage
// Assumes: One clock domain, core_clk, with async active-low rstn
// Notes:   Bound to sffo_core below
`timescale 1ns/1ns
`default_nettype none

module sffo_core_monitor
   import sffo_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Watched inputs
   input wire logic signed [31:0] speed_detect,
   input wire logic ain3_other_function,
   input wire logic servo_on,
   input wire logic [15:0] function_expansion_setting,
   input wire logic [3:0] control_mode_select,
   // Watched outputs
   input wire logic signed [31:0] speed_cmd_out,
   input wire logic signed [15:0] torque_cmd_out,
   input wire logic signed [31:0] speed_fb_out,
   input wire logic ctrl_cycle,
   input wire logic observer_active,
   input wire logic analog_ff_active
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   logic [11:0] gap_reg;
   logic seen_reg;
   wire logic obs_cond = function_expansion_setting[FES_OBS_EN_BIT] && servo_on &&
      (control_mode_select == MODE_POSITION || control_mode_select == MODE_VELOCITY);
   wire logic atff_off = !function_expansion_setting[FES_ATFF_EN_BIT] || ain3_other_function;

   // Cycles since the last control pulse
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         gap_reg <= 12'h000;
         seen_reg <= 1'b0;
      end else if (ctrl_cycle) begin
         gap_reg <= 12'h000;
         seen_reg <= 1'b1;
      end else begin
         gap_reg <= gap_reg + 12'h001;
      end
   end

   a_pulse_period: assert property (ctrl_cycle && seen_reg |-> gap_reg == 12'(CTRL_PERIOD_CYCLES - 1))
      else $error("control pulse spacing wrong");
   a_pulse_single: assert property (ctrl_cycle |=> !ctrl_cycle)
      else $error("control pulse longer than one cycle");
   a_cmd_hold: assert property (!$past(ctrl_cycle) |-> $stable(speed_cmd_out) && $stable(torque_cmd_out))
      else $error("command changed between control pulses");
   a_status_hold: assert property (!$past(ctrl_cycle) |-> $stable(speed_fb_out) && $stable(observer_active))
      else $error("feedback changed between control pulses");
   a_observer_gate: assert property (ctrl_cycle |=> observer_active == $past(obs_cond))
      else $error("observer enable wrong");
   a_analog_off: assert property (ctrl_cycle && atff_off |=> !analog_ff_active)
      else $error("analog feed-forward active while off");
   a_fb_select: assert property (ctrl_cycle && !obs_cond |=> speed_fb_out == $past(speed_detect))
      else $error("detected speed not passed through");
   a_reset_quiet: assert property ($rose(rstn) |-> speed_cmd_out == SPEED_RESET &&
      torque_cmd_out == TORQUE_RESET && !ctrl_cycle)
      else $error("outputs not quiet after reset");

   c_observer: cover property (ctrl_cycle && observer_active);
   c_analog: cover property (ctrl_cycle && analog_ff_active);
   c_torque_sat: cover property (ctrl_cycle && torque_cmd_out == 16'sh7FFF);
endmodule : sffo_core_monitor

bind sffo_core sffo_core_monitor u_monitor (.core_clk, .rstn, .speed_detect, .ain3_other_function,
   .servo_on, .function_expansion_setting, .control_mode_select, .speed_cmd_out, .torque_cmd_out,
   .speed_fb_out, .ctrl_cycle, .observer_active, .analog_ff_active);
`default_nettype wire

// >>> dv/sffo_host_model.sv
// Purpose: Host controller and analog source in front of the stage
// Assumes: Position advances by step_size once per control cycle
// Notes:   Updates land on the falling edge, ahead of the sampling edge
`timescale 1ns/1ns
`default_nettype none

module sffo_host_model (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Pacing and settings
   input wire logic ctrl_cycle,
   input wire logic signed [31:0] step_size,
   input wire logic signed [15:0] analog_set_mv,
   // Toward the stage
   output logic signed [31:0] pos_cmd,
   output logic signed [15:0] analog_in3_mv
);
   always @(negedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pos_cmd <= 32'sh0000_0000;
      end else if (ctrl_cycle) begin
         pos_cmd <= pos_cmd + step_size;
      end
   end
   assign analog_in3_mv = analog_set_mv;
endmodule : sffo_host_model
`default_nettype wire

// >>> dv/servo_feed_forward_observer_test.sv
// Purpose: Self-checking bench for the feed-forward and observer stage
// Assumes: Inputs change on the falling edge of core_clk
// Notes:   One control cycle is 1250 clocks, so scenarios are kept short
`timescale 1ns/1ns
`default_nettype none

module servo_feed_forward_observer_test;
   import sffo_pkg::*;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic signed [31:0] pos_loop_speed_cmd = 32'sh0, speed_detect = 32'sh0BB8, step_size = 32'sh0;
   logic signed [15:0] vel_loop_torque_cmd = 16'sh0, analog_set_mv = 16'sh0;
   logic ain3_other_function = 1'b0, servo_on = 1'b1;
   logic [15:0] velocity_ff_gain = 16'h0, velocity_ff_filter = 16'h0, torque_ff_gain = 16'h0;
   logic [15:0] torque_ff_filter = 16'h0, analog_torque_ff_conversion_gain = 16'h0;
   logic [15:0] function_expansion_setting = 16'h0, inertia_ratio = 16'h0064;
   logic [3:0] control_mode_select = 4'h0;
   wire logic signed [31:0] pos_cmd, speed_cmd_out, speed_fb_out;
   wire logic signed [15:0] analog_in3_mv, torque_cmd_out;
   wire logic ctrl_cycle, observer_active, analog_ff_active;
   int num_errors = 0;
   int n_compared = 0;
   int cycles = 0;

   sffo_host_model u_host (.core_clk, .rstn, .ctrl_cycle, .step_size, .analog_set_mv, .pos_cmd,
      .analog_in3_mv);
   sffo_core DUT (.core_clk, .rstn, .pos_cmd, .pos_loop_speed_cmd, .vel_loop_torque_cmd, .speed_detect,
      .analog_in3_mv, .ain3_other_function, .servo_on, .velocity_ff_gain, .velocity_ff_filter,
      .torque_ff_gain, .torque_ff_filter, .analog_torque_ff_conversion_gain, .function_expansion_setting,
      .control_mode_select, .inertia_ratio, .speed_cmd_out, .torque_cmd_out, .speed_fb_out, .ctrl_cycle,
      .observer_active, .analog_ff_active);

   always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 90000) begin
         num_errors++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("Compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input logic signed [31:0] seen, input logic signed [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %0t: got %0d expected %0d", $time, seen, exp);
      end
   endtask : chk

   task automatic pulses(input int n);
      repeat (n) @(posedge core_clk iff ctrl_cycle === 1'b1);
      @(negedge core_clk);
   endtask : pulses

   task automatic t_reset();
      chk(speed_cmd_out, 0);
      chk(torque_cmd_out, 0);
      pulses(1);
      chk(speed_fb_out, 3000);
      $display("t_reset done");
   endtask : t_reset

   task automatic t_vff();
      logic [15:0] g[3] = '{16'h0000, 16'h01F4, 16'h03E8};
      pos_loop_speed_cmd = 32'sh03E8;
      step_size = 32'sh00C8;
      foreach (g[i]) begin
         velocity_ff_gain = g[i];
         pulses(3);
         chk(speed_cmd_out, 1000 + 200 * int'(g[i]) / 1000);
      end
      step_size = 32'sh0;
      pulses(3);
      chk(speed_cmd_out, 1000);
      pos_loop_speed_cmd = 32'sh0;
      pulses(1);
      $display("t_vff done");
   endtask : t_vff

   task automatic t_filter();
      int k;
      velocity_ff_filter = 16'h0032;
      step_size = 32'sh044C;
      k = 0;
      while (speed_cmd_out === 32'sh0 && k < 6) begin
         pulses(1);
         k++;
      end
      chk(speed_cmd_out, 100);
      step_size = 32'sh0;
      velocity_ff_filter = 16'h0;
      pulses(3);
      $display("t_filter done");
   endtask : t_filter

   task automatic t_tff();
      int k;
      torque_ff_gain = 16'h03E8;
      torque_ff_filter = 16'h0032;
      step_size = 32'sh044C;
      k = 0;
      while (torque_cmd_out === 16'sh0 && k < 6) begin
         pulses(1);
         k++;
      end
      chk(torque_cmd_out, 200);
      step_size = 32'sh0;
      torque_ff_gain = 16'h0;
      torque_ff_filter = 16'h0;
      pulses(4);
      chk(torque_cmd_out, 0);
      $display("t_tff done");
   endtask : t_tff

   task automatic t_analog();
      int r[9][7] = '{'{1, 0, 30, 3000, 0, 1000, 1}, '{1, 0, 30, -3000, 0, -1000, 1}, '{1, 0, 30, -7, 0, -2, 1},
         '{1, 0, 9, 3000, 0, 0, 0}, '{1, 0, 10, 3000, 0, 3000, 1}, '{1, 1, 30, 3000, 0, 0, 0},
         '{0, 0, 30, 3000, 0, 0, 0}, '{1, 0, 10, 3000, 32000, 32767, 1}, '{1, 0, 10, -3000, -32000, -32768, 1}};
      foreach (r[i]) begin
         function_expansion_setting = r[i][0] ? 16'h0020 : 16'h0000;
         ain3_other_function = 1'(r[i][1]);
         analog_torque_ff_conversion_gain = 16'(r[i][2]);
         analog_set_mv = 16'(r[i][3]);
         vel_loop_torque_cmd = 16'(r[i][4]);
         pulses(1);
         chk(torque_cmd_out, r[i][5]);
         chk(analog_ff_active, r[i][6]);
      end
      function_expansion_setting = 16'h0;
      vel_loop_torque_cmd = 16'sh0;
      $display("t_analog done");
   endtask : t_analog

   task automatic t_speed_sat();
      pos_loop_speed_cmd = 32'sh7FFF_FF00;
      step_size = 32'sh03E8;
      pulses(3);
      chk(speed_cmd_out, 32'sh7FFF_FFFF);
      pos_loop_speed_cmd = 32'sh0;
      step_size = 32'sh0;
      pulses(2);
      $display("t_speed_sat done");
   endtask : t_speed_sat

   task automatic t_observer();
      int r[5][5] = '{'{0, 1, 1, 1, 3468}, '{1, 1, 1, 1, 4049}, '{2, 1, 1, 0, 5800}, '{0, 0, 1, 0, 5800},
         '{0, 1, 0, 0, 5800}};
      foreach (r[i]) begin
         speed_detect = 32'sh1388;
         control_mode_select = 4'(r[i][0]);
         servo_on = 1'(r[i][1]);
         function_expansion_setting = 16'(r[i][2]);
         pulses(2);
         speed_detect = 32'sh16A8;
         pulses(1);
         chk(observer_active, r[i][3]);
         chk(speed_fb_out === 32'sh16A8, !r[i][3]);
         chk(speed_fb_out, r[i][4]);
      end
      $display("t_observer done");
   endtask : t_observer

   initial begin
      repeat (8) @(negedge core_clk);
      rstn = 1'b1;
      t_reset();
      t_vff();
      t_filter();
      t_tff();
      t_analog();
      t_speed_sat();
      t_observer();
      end_of_test();
   end
endmodule : servo_feed_forward_observer_test
`default_nettype wire
